// ---- rtl/mba_cfg.svh ----
`ifndef MBA_CFG_SVH
`define MBA_CFG_SVH
// ======================================================
// operand memory geometry
`define MBA_WORDS        96
`define MBA_MAX_MODE     7'h5F
`define MBA_RGN_M        2'h0
`define MBA_RGN_Z        2'h1
`define MBA_RGN_Y        2'h2
`define MBA_RGN_X        2'h3
// ======================================================
// register byte offsets
`define MBA_REG_MPRIME   12'h800
`define MBA_REG_MODE     12'h804
`define MBA_REG_CLEAN    12'h808
`define MBA_REG_EXP      12'h80C
`define MBA_REG_MUL      12'h810
`define MBA_REG_IDLE     12'h818
`define MBA_REG_CLR      12'h81C
`define MBA_REG_CTIME    12'h820
`define MBA_REG_SRCH_EN  12'h824
`define MBA_REG_SRCH_POS 12'h828
`define MBA_REG_INT_ENA  12'h82C
// ======================================================
// reset values
`define MBA_CTIME_RST    1'h1
`define MBA_SRCHEN_RST   1'h0
`define MBA_SRCHPOS_RST  12'h000
`define MBA_INTENA_RST   1'h1
`endif

// ---- rtl/mba_pkg.sv ----
package mba_pkg;
   // ======================================================
   // engine sequencer states
   typedef enum logic [7:0] {
      ST_INIT = 8'b0000_0001,
      ST_IDLE = 8'b0000_0010,
      ST_MQ   = 8'b0000_0100,
      ST_MAC  = 8'b0000_1000,
      ST_TOP  = 8'b0001_0000,
      ST_SUBC = 8'b0010_0000,
      ST_SUBW = 8'b0100_0000,
      ST_NEXT = 8'b1000_0000
   } mba_state_t;
   // montgomery product phases of one operation
   typedef enum logic [6:0] {
      PH_XR  = 7'b000_0001,
      PH_ONE = 7'b000_0010,
      PH_SQ  = 7'b000_0100,
      PH_MUL = 7'b000_1000,
      PH_FIN = 7'b001_0000,
      PH_MM1 = 7'b010_0000,
      PH_MM2 = 7'b100_0000
   } mba_phase_t;
   // operand source or destination; low bits are the memory region
   typedef enum logic [2:0] {
      SRC_M    = 3'h0,
      SRC_Z    = 3'h1,
      SRC_Y    = 3'h2,
      SRC_X    = 3'h3,
      SRC_ONE  = 3'h4,
      SRC_NONE = 3'h5
   } mba_src_t;
endpackage : mba_pkg

// ---- rtl/mba_top.sv ----
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "mba_cfg.svh"
// Notes on behaviour
// - engine held in reset unless clock enable set and power-down clear
// - memories cleared after release; clean flag 0 then 1
// - interrupt enable gates completion interrupt; enabled after reset
// - exponentiation computes X^Y mod M via Montgomery products
// - length is 32 times 1..96 bits, shared by all operands
// - inverse word is 32 bits in its own register
// - one 32-bit digit per word, least significant lowest
// - four operand memories of 96 words each
// - words beyond configured length are not used
// - writing 1 to exponentiation start launches it
// - idle flag 1 and interrupt mark completion
// - result left in Z memory little-endian
// - writing 1 to clear deasserts pending interrupt
// - exponentiation keeps length, Y, M, inverse; X and Z overwritten
// - modular product computes X*Y mod M via Montgomery products
// - writing 1 to product start launches it
// - product keeps length, X, Y, M, inverse; only Z overwritten
// - constant-time 0 skips zero-bit multiplies; 1 is default
// - search enabled starts scanning at the search position
module mba_top
   import mba_pkg::*;
#(
   parameter int WORDS = `MBA_WORDS
) (
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   input  wire logic        pubkey_engine_clock_enable_in,
   input  wire logic        pubkey_memory_power_down_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   output logic             irq_out
);
   // ======================================================
   // release synchronisers
   logic ce_m_r, ce_r, pd_m_r, pd_r, run_rst_n;
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         ce_m_r <= 1'b0;
         ce_r   <= 1'b0;
         pd_m_r <= 1'b1;
         pd_r   <= 1'b1;
      end else begin
         ce_m_r <= pubkey_engine_clock_enable_in;
         ce_r   <= ce_m_r;
         pd_m_r <= pubkey_memory_power_down_in;
         pd_r   <= pd_m_r;
      end
   end
   assign run_rst_n = rst_n_in & ce_r & ~pd_r;

   // ======================================================
   // storage
   logic [31:0] mem_r [0:3][0:WORDS-1];
   logic [31:0] tmp_r [0:WORDS];
   mba_state_t  st_r, st_nxt;
   mba_phase_t  ph_r, ph_nxt;
   logic [6:0]  i_r, i_nxt, j_r, j_nxt, mode_r, mode_nxt;
   logic [11:0] pos_r, pos_nxt, spos_r, spos_nxt;
   logic [31:0] q_r, q_nxt, mpr_r, mpr_nxt;
   logic [33:0] cy_r, cy_nxt;
   logic        br_r, br_nxt, ge_r, ge_nxt;
   logic        ctime_r, ctime_nxt, sen_r, sen_nxt;
   logic        iena_r, iena_nxt, pend_r, pend_nxt, done;
   logic [11:0] a_r;
   logic        wr_r;
   logic [31:0] hrdata_r, rd_val;

   // operand word, with a constant one as a pseudo source
   function automatic logic [31:0] opw(mba_src_t s, logic [6:0] k);
      if (s == SRC_ONE) begin
         opw = (k == 7'h00) ? 32'h0000_0001 : 32'h0000_0000;
      end else begin
         opw = mem_r[s[1:0]][k];
      end
   endfunction : opw

   // ======================================================
   // bus side write strobes
   logic wr_go;
   logic start_exp, start_mul, int_clr, idle, clean;
   assign wr_go     = wr_r;
   assign start_exp = wr_go && a_r == `MBA_REG_EXP && hwdata_in[0];
   assign start_mul = wr_go && a_r == `MBA_REG_MUL && hwdata_in[0];
   assign int_clr   = wr_go && a_r == `MBA_REG_CLR && hwdata_in[0];
   assign idle      = (st_r == ST_IDLE);
   assign clean     = (st_r != ST_INIT);

   // ======================================================
   // datapath terms
   mba_src_t    src_a, src_b, dst;
   logic        ybit;
   logic [31:0] aj, bi, tmac, mj, a0;
   logic [63:0] qs;
   logic [65:0] mac_s, top_s;
   logic [32:0] sub_d;
   logic [6:0]  n1;
   assign n1   = mode_r + 7'h01;
   always_comb ybit = mem_y_bit(pos_r); // follows Y memory writes too
   function automatic logic mem_y_bit(logic [11:0] p);
      logic [31:0] w;
      w = mem_r[`MBA_RGN_Y][p[11:5]];
      mem_y_bit = w[p[4:0]];
   endfunction : mem_y_bit

   // operand routing per phase
   always_comb begin
      src_a = SRC_Z;
      src_b = SRC_ONE;
      dst   = SRC_Z;
      case (ph_r)
         PH_XR:  begin src_a = SRC_X; src_b = SRC_Z; dst = SRC_X; end
         PH_ONE: begin src_b = SRC_ONE; end
         PH_SQ:  begin src_b = SRC_Z; end
         PH_MUL: begin
            src_b = SRC_X;
            dst   = ybit ? SRC_Z : SRC_NONE;
         end
         PH_FIN: begin src_b = SRC_ONE; end
         PH_MM1: begin src_b = SRC_X; end
         PH_MM2: begin src_b = SRC_Y; end
         default: begin dst = SRC_NONE; end
      endcase
   end

   // word arithmetic, only digits below the length are touched
   always_comb begin
      aj    = opw(src_a, j_r);
      a0    = opw(src_a, 7'h00);
      bi    = opw(src_b, i_r);
      tmac  = (i_r == 7'h00) ? 32'h0000_0000 : tmp_r[j_r];
      mj    = (j_r <= mode_r) ? mem_r[`MBA_RGN_M][j_r] : 32'h0000_0000;
      qs    = 64'(tmac) + 64'(a0) * 64'(bi);
      mac_s = 66'(tmac) + 66'(aj) * 66'(bi) + 66'(q_r) * 66'(mj)
            + 66'(cy_r);
      top_s = 66'((i_r == 7'h00) ? 32'h0000_0000 : tmp_r[n1]) + 66'(cy_r);
      sub_d = {1'b0, tmp_r[j_r]} - {1'b0, mj} - 33'(br_r);
   end

   // ======================================================
   // engine sequencer
   logic [3:0]  mwe;
   logic [6:0]  mwa;
   logic [31:0] mwd;
   logic        twe, twe2;
   logic [6:0]  twa;
   logic [31:0] twd, twd2;
   always_comb begin
      st_nxt = st_r;   ph_nxt = ph_r;   i_nxt = i_r;   j_nxt = j_r;
      pos_nxt = pos_r; q_nxt = q_r;     cy_nxt = cy_r; br_nxt = br_r;
      ge_nxt = ge_r;   done = 1'b0;
      mwe = 4'h0;      mwa = j_r;       mwd = 32'h0000_0000;
      twe = 1'b0;      twe2 = 1'b0;     twa = j_r - 7'h01;
      twd = mac_s[31:0];
      twd2 = top_s[63:32];
      case (st_r)
         ST_INIT: begin
            mwe   = 4'hF;
            j_nxt = j_r + 7'h01;
            if (j_r == 7'(WORDS - 1)) begin
               st_nxt = ST_IDLE;
               j_nxt  = 7'h00;
            end
         end
         ST_IDLE: begin
            i_nxt = 7'h00;
            if (start_exp) begin
               ph_nxt = PH_XR;
               st_nxt = ST_MQ;
            end else if (start_mul) begin
               ph_nxt = PH_MM1;
               st_nxt = ST_MQ;
            end
            if (wr_go && !a_r[11] && a_r[8:2] < 7'(WORDS)) begin
               mwe[a_r[10:9]] = 1'b1;
               mwa = a_r[8:2];
               mwd = hwdata_in;
            end
         end
         ST_MQ: begin
            q_nxt  = qs[31:0] * mpr_r;
            cy_nxt = 34'h0_0000_0000;
            j_nxt  = 7'h00;
            st_nxt = ST_MAC;
         end
         ST_MAC: begin
            twe    = (j_r != 7'h00);
            cy_nxt = mac_s[65:32];
            j_nxt  = j_r + 7'h01;
            if (j_r == mode_r) st_nxt = ST_TOP;
         end
         ST_TOP: begin
            twe  = 1'b1;
            twe2 = 1'b1;
            twa  = mode_r;
            twd  = top_s[31:0];
            j_nxt = 7'h00;
            br_nxt = 1'b0;
            i_nxt = i_r + 7'h01;
            st_nxt = (i_r == mode_r) ? ST_SUBC : ST_MQ;
         end
         ST_SUBC: begin // final conditional subtraction
            br_nxt = sub_d[32];
            j_nxt  = j_r + 7'h01;
            if (j_r == n1) begin
               ge_nxt = ~sub_d[32];
               br_nxt = 1'b0;
               j_nxt  = 7'h00;
               st_nxt = (dst == SRC_NONE) ? ST_NEXT : ST_SUBW;
            end
         end
         ST_SUBW: begin
            mwe[dst[1:0]] = 1'b1;
            mwd    = ge_r ? sub_d[31:0] : tmp_r[j_r];
            br_nxt = sub_d[32];
            j_nxt  = j_r + 7'h01;
            if (j_r == mode_r) st_nxt = ST_NEXT;
         end
         ST_NEXT: begin
            st_nxt = ST_MQ;
            i_nxt  = 7'h00;
            case (ph_r)
               PH_XR:  ph_nxt = PH_ONE;
               PH_ONE: begin
                  ph_nxt  = PH_SQ;
                  pos_nxt = sen_r ? spos_r : 12'({n1, 5'h00} - 12'h001);
               end
               PH_SQ: begin
                  if (ybit || ctime_r) begin
                     ph_nxt = PH_MUL;
                  end else if (pos_r == 12'h000) begin
                     ph_nxt = PH_FIN;
                  end else begin
                     pos_nxt = pos_r - 12'h001;
                  end
               end
               PH_MUL: begin
                  ph_nxt = (pos_r == 12'h000) ? PH_FIN : PH_SQ;
                  pos_nxt = pos_r - 12'h001;
               end
               PH_MM1: ph_nxt = PH_MM2;
               default: begin
                  st_nxt = ST_IDLE;
                  done   = 1'b1;
               end
            endcase
         end
         default: st_nxt = ST_INIT;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!run_rst_n) begin
         st_r <= ST_INIT;  ph_r <= PH_MM1;  i_r <= 7'h00;  j_r <= 7'h00;
         pos_r <= 12'h000; q_r <= 32'h0000_0000;
         cy_r <= 34'h0_0000_0000; br_r <= 1'b0; ge_r <= 1'b0;
      end else begin
         st_r <= st_nxt;   ph_r <= ph_nxt;  i_r <= i_nxt;  j_r <= j_nxt;
         pos_r <= pos_nxt; q_r <= q_nxt;
         cy_r <= cy_nxt;   br_r <= br_nxt;  ge_r <= ge_nxt;
      end
   end

   // memory and scratch write ports
   always_ff @(posedge mclk_in) begin
      for (int r = 0; r < 4; r++) begin
         if (mwe[r]) mem_r[r][mwa] <= mwd;
      end
      if (twe)  tmp_r[twa] <= twd;
      if (twe2) tmp_r[n1]  <= twd2;
   end

   // ======================================================
   // configuration and interrupt registers
   always_comb begin
      mode_nxt = mode_r;  mpr_nxt = mpr_r;   ctime_nxt = ctime_r;
      sen_nxt = sen_r;    spos_nxt = spos_r; iena_nxt = iena_r;
      if (wr_go) begin
         case (a_r)
            `MBA_REG_MODE: mode_nxt = (hwdata_in[6:0] > `MBA_MAX_MODE)
                                      ? `MBA_MAX_MODE : hwdata_in[6:0];
            `MBA_REG_MPRIME:   mpr_nxt   = hwdata_in;
            `MBA_REG_CTIME:    ctime_nxt = hwdata_in[0];
            `MBA_REG_SRCH_EN:  sen_nxt   = hwdata_in[0];
            `MBA_REG_SRCH_POS: spos_nxt  = hwdata_in[11:0];
            `MBA_REG_INT_ENA:  iena_nxt  = hwdata_in[0];
            default: mpr_nxt = mpr_r;
         endcase
      end
      pend_nxt = done | (pend_r & ~int_clr);
   end

   always_ff @(posedge mclk_in) begin
      if (!run_rst_n) begin
         mode_r <= 7'h00;  mpr_r <= 32'h0000_0000;
         ctime_r <= `MBA_CTIME_RST;   sen_r <= `MBA_SRCHEN_RST;
         spos_r <= `MBA_SRCHPOS_RST; iena_r <= `MBA_INTENA_RST;
         pend_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt; mpr_r <= mpr_nxt;
         ctime_r <= ctime_nxt; sen_r <= sen_nxt;
         spos_r <= spos_nxt; iena_r <= iena_nxt;
         pend_r <= pend_nxt;
      end
   end
   assign irq_out = pend_r & iena_r;

   // ======================================================
   // bus slave: zero wait, read data sampled at address phase
   logic        ap;
   logic [11:0] ha;
   assign ap = hsel_in & hready_in & htrans_in[1];
   assign ha = {haddr_in[11:2], 2'h0};
   always_comb begin
      rd_val = 32'h0000_0000;
      if (!ha[11]) begin
         if (ha[8:2] < 7'(WORDS)) rd_val = mem_r[ha[10:9]][ha[8:2]];
      end else begin
         case (ha)
            `MBA_REG_MPRIME:   rd_val = mpr_r;
            `MBA_REG_MODE:     rd_val = {25'h000_0000, mode_r};
            `MBA_REG_CLEAN:    rd_val = {31'h0000_0000, clean};
            `MBA_REG_IDLE:     rd_val = {31'h0000_0000, idle};
            `MBA_REG_CTIME:    rd_val = {31'h0000_0000, ctime_r};
            `MBA_REG_SRCH_EN:  rd_val = {31'h0000_0000, sen_r};
            `MBA_REG_SRCH_POS: rd_val = {20'h0_0000, spos_r};
            `MBA_REG_INT_ENA:  rd_val = {31'h0000_0000, iena_r};
            default:           rd_val = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         a_r <= 12'h000;
         wr_r <= 1'b0;
         hrdata_r <= 32'h0000_0000;
      end else begin
         a_r <= ha;
         wr_r <= ap & hwrite_in;
         hrdata_r <= (ap & ~hwrite_in) ? rd_val : hrdata_r;
      end
   end
   assign hrdata_out    = hrdata_r;
   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;

   // ======================================================
   // assertions
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   a_held_reset: assert property (!run_rst_n |=> st_r == ST_INIT)
      else $error("engine left reset while held");
   a_init_end: assert property (
      st_r == ST_INIT && j_r == 7'(WORDS-1) && run_rst_n |=> clean && idle)
      else $error("clean flag not raised after clear");
   a_irq_gate: assert property (irq_out |-> iena_r && pend_r)
      else $error("interrupt raised while disabled");
   a_done_irq: assert property (disable iff (!run_rst_n)
      done && iena_r |=> irq_out && idle)
      else $error("completion not signalled");
   a_irq_clear: assert property (disable iff (!run_rst_n)
      int_clr && !done |=> !irq_out)
      else $error("interrupt not cleared");
   a_idle_drop: assert property (disable iff (!run_rst_n)
      idle && (start_exp || start_mul) |=> !idle ##1 !idle)
      else $error("idle flag did not drop");
   // a taken start would send the sequencer back to the q step
   a_busy_ignore: assert property (disable iff (!run_rst_n)
      !idle && clean && (start_exp || start_mul) && st_r != ST_NEXT
      && st_r != ST_TOP |=> $stable(ph_r) && st_r != ST_MQ)
      else $error("start accepted while busy");
   a_keep_y_m: assert property (!idle && clean |-> !mwe[`MBA_RGN_Y]
      && !mwe[`MBA_RGN_M])
      else $error("Y or M memory written by engine");
   a_mul_keep_x: assert property (
      !idle && clean && ph_r inside {PH_MM1, PH_MM2} |-> !mwe[`MBA_RGN_X])
      else $error("X memory written by modular product");
   a_len_limit: assert property (mode_r <= `MBA_MAX_MODE)
      else $error("length beyond 96 digits");
   a_skip_zero: assert property (disable iff (!run_rst_n)
      st_r == ST_NEXT && ph_r == PH_SQ && !ybit && !ctime_r
      |=> ph_r != PH_MUL)
      else $error("zero bit multiply not skipped");
   a_search_pos: assert property (disable iff (!run_rst_n)
      st_r == ST_NEXT && ph_r == PH_ONE && sen_r
      |=> pos_r == spos_r)
      else $error("scan did not start at search position");

   c_exp_done: cover property (done && ph_r == PH_FIN);
   c_mul_done: cover property (done && ph_r == PH_MM2);
   c_irq_clr: cover property (irq_out ##1 int_clr ##1 !irq_out);
   c_busy_start: cover property (!idle && clean && start_exp);
endmodule : mba_top

// ---- verification/mba_tb_top.sv ----
`timescale 1ns/1ps
`include "mba_cfg.svh"
module mba_tb_top;
   logic         mclk_in = 1'h0;
   logic         rst_n_in = 1'h0;
   logic         clk_en = 1'h0;
   logic         pwr_dn = 1'h1;
   logic         hsel = 1'h0;
   logic         hwrite = 1'h0;
   logic [1:0]   htrans = 2'h0;
   logic [2:0]   hsize = 3'h2;
   logic [31:0]  haddr = 32'h0000_0000;
   logic [31:0]  hwdata = 32'h0000_0000;
   logic [31:0]  hrdata;
   logic         hreadyout;
   logic         hresp;
   logic         irq;
   logic [31:0]  q;
   int           bad_count = 0;
   int           n_checks = 0;
   int           cycles = 0;
   int           seed = 81016;
   int           k;

   // ======================================================
   // device under test, single slave so hready loops back
   mba_top u_dut (
      .mclk_in                       (mclk_in),
      .rst_n_in                      (rst_n_in),
      .pubkey_engine_clock_enable_in (clk_en),
      .pubkey_memory_power_down_in   (pwr_dn),
      .hsel_in                       (hsel),
      .haddr_in                      (haddr),
      .htrans_in                     (htrans),
      .hwrite_in                     (hwrite),
      .hsize_in                      (hsize),
      .hwdata_in                     (hwdata),
      .hready_in                     (hreadyout),
      .hrdata_out                    (hrdata),
      .hreadyout_out                 (hreadyout),
      .hresp_out                     (hresp),
      .irq_out                       (irq)
   );

   // ======================================================
   // clock and hang guard
   initial begin
      forever #10 mclk_in = ~mclk_in;
   end

   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         report_and_stop();
      end
   end

   // ======================================================
   // helpers
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one single word transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge mclk_in);
      hsel   <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {20'h0_0000, a};
      @(posedge mclk_in);
      while (hreadyout !== 1'h1) @(posedge mclk_in);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge mclk_in);
      while (hreadyout !== 1'h1) @(posedge mclk_in);
      r = hrdata;
      chk({31'h0, hresp}, 32'h0000_0000); // response must be OKAY
   endtask : bus

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'h1, a, d, r);
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] r);
      bus(1'h0, a, 32'h0000_0000, r);
   endtask : rd

   // read until bit 0 is set or the budget runs out
   task automatic poll(input logic [11:0] a, output logic [31:0] r);
      int i;
      i = 0;
      rd(a, r);
      while (r[0] !== 1'h1 && i < 3000) begin
         rd(a, r);
         i++;
      end
   endtask : poll

   function automatic logic [11:0] ma(input logic [1:0] g, input int i);
      return {1'h0, g, 9'h000} + 12'(i * 4);
   endfunction : ma

   function automatic logic [191:0] mmul(input logic [191:0] x, y, m);
      return (x * y) % m;
   endfunction : mmul

   // square and multiply reference, lsb first
   function automatic logic [191:0] mexp(input logic [191:0] x, y, m);
      logic [191:0] r;
      r = 192'h1;
      for (int i = 0; i < 64; i++) begin
         if (y[i]) r = mmul(r, x, m);
         x = mmul(x, x, m);
      end
      return r;
   endfunction : mexp

   // negative inverse of the low modulus digit
   function automatic logic [31:0] minv(input logic [31:0] m0);
      logic [31:0] v;
      v = m0;
      repeat (4) v = v * (32'h0000_0002 - m0 * v);
      return -v;
   endfunction : minv

   // ======================================================
   // one full operation with random operands and junk past n
   task automatic run_op(input int n, input logic ex, input logic ct,
                         input logic se, input logic ie);
      logic [191:0] x, y, m, msk, z, rr;
      logic [31:0]  r;
      int           t;
      msk = (192'h1 << (32 * n)) - 192'h1;
      m = {$random(seed), $random(seed)} & msk;
      m[0] = 1'h1;
      m[32 * n - 1] = 1'h1;
      x = ({$random(seed), $random(seed)} & msk) % m;
      y = {$random(seed), $random(seed)} & msk;
      t = 0;
      for (int i = 0; i < 64; i++) if (y[i]) t = i;
      z = ex ? mexp(x, y, m) : mmul(x, y, m);
      rr = (192'h1 << (64 * n)) % m;
      wr(`MBA_REG_INT_ENA, {31'h0, ie});
      wr(`MBA_REG_MODE, 32'(n - 1));
      wr(`MBA_REG_MPRIME, minv(m[31:0]));
      wr(`MBA_REG_CTIME, {31'h0, ct});
      wr(`MBA_REG_SRCH_EN, {31'h0, se});
      wr(`MBA_REG_SRCH_POS, 32'(t));
      for (int i = 0; i <= n; i++) begin
         wr(ma(`MBA_RGN_X, i), i < n ? x[32*i+:32] : $random(seed));
         wr(ma(`MBA_RGN_Y, i), i < n ? y[32*i+:32] : $random(seed));
         wr(ma(`MBA_RGN_M, i), i < n ? m[32*i+:32] : $random(seed));
         wr(ma(`MBA_RGN_Z, i), i < n ? rr[32*i+:32] : $random(seed));
      end
      wr(ex ? `MBA_REG_EXP : `MBA_REG_MUL, 32'h0000_0001);
      rd(`MBA_REG_IDLE, r);
      chk(r, 32'h0000_0000);
      wr(ex ? `MBA_REG_MUL : `MBA_REG_EXP, 32'h0000_0001);
      wr(ma(`MBA_RGN_Y, 0), ~y[31:0]);
      poll(`MBA_REG_IDLE, r);
      chk(r, 32'h0000_0001);
      chk({31'h0, irq}, {31'h0, ie});
      wr(`MBA_REG_CLR, 32'h0000_0001);
      rd(`MBA_REG_IDLE, r);
      chk({31'h0, irq}, 32'h0000_0000);
      for (int i = 0; i < n; i++) begin
         rd(ma(`MBA_RGN_Z, i), r);
         chk(r, z[32*i+:32]);
         rd(ma(`MBA_RGN_Y, i), r);
         chk(r, y[32*i+:32]);
         rd(ma(`MBA_RGN_M, i), r);
         chk(r, m[32*i+:32]);
         rd(ma(`MBA_RGN_X, i), r);
         if (!ex) chk(r, x[32*i+:32]);
      end
      rd(`MBA_REG_MODE, r);
      chk(r, 32'(n - 1));
      rd(`MBA_REG_MPRIME, r);
      chk(r, minv(m[31:0]));
      $display("op done n %0d exp %0d ct %0d search %0d", n, ex, ct, se);
   endtask : run_op

   // ======================================================
   // main sequence
   initial begin
      repeat (4) @(posedge mclk_in);
      rst_n_in <= 1'h1;
      rd(`MBA_REG_CLEAN, q);
      chk(q, 32'h0000_0000);
      rd(`MBA_REG_IDLE, q);
      chk(q, 32'h0000_0000);
      wr(`MBA_REG_INT_ENA, 32'h0000_0000);
      clk_en <= 1'h1;
      repeat (8) @(posedge mclk_in);
      rd(`MBA_REG_CLEAN, q);
      chk(q, 32'h0000_0000);
      pwr_dn <= 1'h0;
      rd(`MBA_REG_CLEAN, q);
      chk(q, 32'h0000_0000);
      poll(`MBA_REG_CLEAN, q);
      chk(q, 32'h0000_0001);
      rd(`MBA_REG_CTIME, q);
      chk(q, 32'h0000_0001);
      rd(`MBA_REG_SRCH_EN, q);
      chk(q, 32'h0000_0000);
      rd(`MBA_REG_SRCH_POS, q);
      chk(q, 32'h0000_0000);
      rd(`MBA_REG_INT_ENA, q);
      chk(q, 32'h0000_0001);
      rd(ma(`MBA_RGN_Z, 95), q);
      chk(q, 32'h0000_0000);
      wr(ma(`MBA_RGN_X, 95), 32'hA5C3_0F96);
      rd(ma(`MBA_RGN_X, 95), q);
      chk(q, 32'hA5C3_0F96);
      rd(12'hFFC, q);
      chk(q, 32'h0000_0000);
      wr(`MBA_REG_MODE, 32'h0000_007F);
      rd(`MBA_REG_MODE, q);
      chk(q, 32'h0000_005F);
      $display("reset and init test done");
      // product, then exponent with three ct/search mixes (never both set); odd k masks irq
      for (k = 0; k < 8; k++) begin
         run_op(1 + k % 2, k >= 2, k < 4, k >= 6, k % 2 == 0);
      end
      // engine reset while idle by dropping the clock enable
      clk_en <= 1'h0;
      repeat (4) @(posedge mclk_in);
      rd(`MBA_REG_IDLE, q);
      chk(q, 32'h0000_0000);
      rd(`MBA_REG_INT_ENA, q);
      chk(q, 32'h0000_0001);
      clk_en <= 1'h1;
      poll(`MBA_REG_CLEAN, q);
      chk(q, 32'h0000_0001);
      rd(ma(`MBA_RGN_Y, 0), q);
      chk(q, 32'h0000_0000);
      $display("engine reset test done");
      report_and_stop();
   end
endmodule : mba_tb_top
